// file: cpr_checker.sv
// concurrent checks on apb timing, sample pacing and panel state of the regulator
`timescale 1ns/1ps
`default_nettype none
`include "cpr_map.svh"
module cpr_checker (
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic [31:0] o_prdata,
	input  wire logic        o_pready,
	input  wire logic        o_pslverr,
	input  wire logic [15:0] o_drive,
	input  wire logic        o_panel_off,
	input  wire logic        o_running
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	logic [11:0] gap;
	logic        armed;
	// the first update after a start is not aligned to the sample grid, so pacing waits for one
	always_ff @(posedge i_clk) begin
		if (!i_nrst || !o_running || $changed(o_drive))
			gap <= 12'h000;
		else if (gap != 12'hfff)
			gap <= gap + 12'h001;
	end
	always_ff @(posedge i_clk) begin
		if (!i_nrst || !o_running)
			armed <= 1'b0;
		else if ($changed(o_drive))
			armed <= 1'b1;
	end
	a_ready_setup: assert property (i_psel && !i_penable |=> o_pready)
		else $error("no answer in first access cycle");
	a_ready_pulse: assert property (o_pready |=> !o_pready)
		else $error("ready stood longer than one cycle");
	a_ready_access: assert property (o_pready |-> i_psel && i_penable)
		else $error("ready outside access phase");
	a_err_unmapped: assert property (o_pready && i_paddr > 12'h074 |-> o_pslverr)
		else $error("unmapped access not refused");
	a_ok_mapped: assert property (o_pready && i_paddr <= `CPR_A_LOCAL_SP |-> !o_pslverr)
		else $error("mapped access refused");
	a_period_value: assert property (o_pready && !i_pwrite && i_paddr == `CPR_A_PERIOD
		|-> o_prdata == 32'h0000_001d)
		else $error("sample period read wrong");
	a_idle_off: assert property (!o_running [*3] |-> o_panel_off)
		else $error("panel not off while stopped");
	a_remote_off: assert property (o_pready && i_pwrite && i_paddr == `CPR_A_CTRL && i_pwdata[0]
		|-> ##[1:4] o_panel_off)
		else $error("panel not off in remote");
	a_idle_drive: assert property (!o_running [*8] |-> o_drive == 16'h0000)
		else $error("drive not zero while stopped");
	a_drive_pace: assert property ($changed(o_drive) && armed && o_running |-> gap >= 12'd3624)
		else $error("drive updated faster than sample period");
	c_refused: cover property (o_pready && o_pslverr);
	c_paced: cover property ($changed(o_drive) && armed);
	c_remote_run: cover property (o_running && o_panel_off);
endmodule : cpr_checker
bind cpr_top cpr_checker u_chk (.i_clk, .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
	.i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_drive, .o_panel_off, .o_running);
`default_nettype wire

// file: cpr_host.sv
// configuration host model: reads and writes the regulator over apb
`timescale 1ns/1ps
`default_nettype none
module cpr_host (
	input  wire logic        i_clk,
	input  wire logic [31:0] i_prdata,
	input  wire logic        i_pready,
	input  wire logic        i_pslverr,
	output logic             o_psel,
	output logic             o_penable,
	output logic             o_pwrite,
	output logic      [11:0] o_paddr,
	output logic      [31:0] o_pwdata
);
	initial begin
		o_psel = 1'b0;
		o_penable = 1'b0;
		o_pwrite = 1'b0;
		o_paddr = 12'h000;
		o_pwdata = 32'h0000_0000;
	end
	// apb access stands in for the fixed-rate host link
	// request is held until ready is sampled, the only edge where data is taken
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge i_clk);
		o_psel <= 1'b1;
		o_pwrite <= w;
		o_paddr <= a;
		o_pwdata <= d;
		@(posedge i_clk);
		o_penable <= 1'b1;
		@(posedge i_clk);
		while (i_pready !== 1'b1)
			@(posedge i_clk);
		q = i_prdata;
		e = i_pslverr;
		o_psel <= 1'b0;
		o_penable <= 1'b0;
	endtask : xfer
endmodule : cpr_host
`default_nettype wire

// file: cpr_log.sv
// error log: entries of power-on count and code, cleared whole
`timescale 1ns/1ps
`default_nettype none
`include "cpr_map.svh"
module cpr_log
	import cpr_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_push,
	input  wire logic [15:0] i_code,
	input  wire logic [15:0] i_poweron,
	input  wire logic        i_clear,
	input  wire logic [2:0]  i_rd_idx,
	output logic      [31:0] o_rd_data,
	output logic      [3:0]  o_count
);
	logic [31:0] mem [`CPR_LOG_DEPTH];
	logic [2:0]  wr_idx;

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			wr_idx  <= 3'd0;
			o_count <= 4'd0;
		end else if (i_clear) begin
			// an event in the clearing cycle survives as the first entry
			if (i_push) begin
				mem[0]  <= {i_poweron, i_code};
				wr_idx  <= 3'd1;
				o_count <= 4'd1;
			end else begin
				wr_idx  <= 3'd0;
				o_count <= 4'd0;
			end
		end else if (i_push) begin
			mem[wr_idx] <= {i_poweron, i_code};
			wr_idx      <= wr_idx + 3'd1;
			if (o_count != 4'(`CPR_LOG_DEPTH))
				o_count <= o_count + 4'd1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst)
			o_rd_data <= 32'h0000_0000;
		else
			o_rd_data <= (4'(i_rd_idx) < o_count) ? mem[i_rd_idx] : 32'h0000_0000;
	end
endmodule : cpr_log
`default_nettype wire

// file: cpr_map.svh
// register offsets, field positions, reset values and timing counts of the cascaded regulator
// Behaviour
// - two loops in cascade: current inner, voltage outer
// - outer: setpoint reference, voltage feedback, yields current demand
// - inner: adapted demand reference, current feedback, faster; the code steps it on the outer loop's strobe, one cycle later
// - proportional gain per loop, 0 to 10000
// - integral span 0 disables, up to 32000
// - per-loop select: span as set or gain-scaled
// - derivative span likewise, 0 disables, gain-scaled option
// - integral accumulator clamped between settable limits
// - derivative term clamped between settable limits
// - feed-forward 0 to 20 anticipates current demand
// - fixed sample period, reported to host
// - configuration link runs at 9600 baud; the code has no serial link, an apb slave takes its place
// - reset command clears latched alarms
// - remote control ignores local inputs, panel shows off
// - log entry holds power-on count and code
// - time counter restarts at power-up, host settable
// - clear command erases whole error log
// - writes store, reads return held values
// - mode selects internal or external setpoint
`ifndef CPR_MAP_SVH
`define CPR_MAP_SVH
`define CPR_A_CTRL        12'h000
`define CPR_A_STATUS      12'h004
`define CPR_A_FF          12'h008
`define CPR_A_PERIOD      12'h00C
`define CPR_A_TIME        12'h010
`define CPR_A_POWERON     12'h014
`define CPR_A_ALARM       12'h018
`define CPR_A_LOGCNT      12'h01C
`define CPR_A_LOGRD       12'h020
`define CPR_A_LOCAL_SP    12'h024
`define CPR_A_OUT_KP      12'h040
`define CPR_A_IN_KP       12'h060
`define CPR_O_KP          12'h000
`define CPR_O_TI          12'h004
`define CPR_O_TD          12'h008
`define CPR_O_ILIM        12'h00C
`define CPR_O_DLIM        12'h010
`define CPR_O_SEL         12'h014
`define CPR_B_REMOTE      0
`define CPR_B_EXTREF      1
`define CPR_B_ALMRST      2
`define CPR_B_LOGCLR      3
`define CPR_B_RUN         4
`define CPR_KP_MAX        16'd10000
`define CPR_SPAN_MAX      16'd32000
`define CPR_FF_MAX        16'd20
`define CPR_CLK_MHZ       125
`define CPR_SAMPLE_NS     29000
`define CPR_SAMPLE_CYC    ((`CPR_SAMPLE_NS * `CPR_CLK_MHZ) / 1000)
`define CPR_SAMPLE_US     16'd29
`define CPR_US_CYC        `CPR_CLK_MHZ
`define CPR_LOG_DEPTH     8
`define CPR_RST_KP        16'd50
`define CPR_RST_TI        16'd200
`define CPR_RST_TD        16'd250
`define CPR_RST_LIM       8'd100
`endif

// file: cpr_pid.sv
// one pid loop evaluated on a strobe: p + clamped i + clamped d
`timescale 1ns/1ps
`default_nettype none
`include "cpr_map.svh"
module cpr_pid
	import cpr_pkg::*;
(
	input  wire logic               i_clk,
	input  wire logic               i_nrst,
	input  wire logic               i_step,
	input  wire logic signed [15:0] i_ref,
	input  wire logic signed [15:0] i_fb,
	input  wire logic        [15:0] i_kp,
	input  wire logic        [15:0] i_ti,
	input  wire logic        [15:0] i_td,
	input  wire logic        [7:0]  i_ineg,
	input  wire logic        [7:0]  i_ipos,
	input  wire logic        [7:0]  i_dneg,
	input  wire logic        [7:0]  i_dpos,
	input  wire logic               i_iscale,
	input  wire logic               i_dscale,
	output logic signed      [15:0] o_y
);
	logic signed [31:0] integ;
	logic signed [15:0] prev_err;

	// percent of 16-bit full scale, as a signed limit
	function automatic logic signed [31:0] pct(input logic [7:0] p);
		logic [31:0] v;
		v = (32'(p) * 32'd32767) / 32'd100;
		return $signed(v);
	endfunction : pct

	function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
		input logic signed [31:0] lo, input logic signed [31:0] hi);
		return (v > hi) ? hi : ((v < lo) ? lo : v);
	endfunction : clamp

	function automatic logic [31:0] eff_span(input logic [15:0] s, input logic sc, input logic [15:0] kp);
		logic [31:0] v;
		v = sc ? 32'(s) * 32'(kp) : 32'(s);
		return (v == 32'h0000_0000) ? 32'h0000_0001 : v;
	endfunction : eff_span

	logic signed [31:0] err;
	logic signed [31:0] pterm;
	logic signed [31:0] next_integ;
	logic signed [31:0] next_dterm;
	logic signed [31:0] sum;
	always_comb begin
		err        = 32'(i_ref) - 32'(i_fb);
		pterm      = (err * $signed(32'(i_kp))) >>> 8;
		// spans in us; error scaled by sample/span per step
		next_integ = (i_ti == 16'h0000) ? 32'sd0 : clamp(integ + ((err * 32'sd29) / $signed(eff_span(i_ti, i_iscale, i_kp))),
			-pct(i_ineg), pct(i_ipos));
		next_dterm = (i_td == 16'h0000) ? 32'sd0 : clamp(((err - 32'(prev_err)) * $signed(eff_span(i_td, i_dscale, i_kp))) / 32'sd29,
			-pct(i_dneg), pct(i_dpos));
		sum        = clamp(pterm + next_integ + next_dterm, -32'sd32768, 32'sd32767);
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			integ    <= 32'sd0;
			prev_err <= 16'sd0;
			o_y      <= 16'sd0;
		end else if (i_step) begin
			integ    <= next_integ;
			prev_err <= 16'(clamp(err, -32'sd32768, 32'sd32767));
			o_y      <= sum[15:0];
		end
	end
endmodule : cpr_pid
`default_nettype wire

// file: cpr_pkg.sv
// types shared by the cascaded regulator modules
package cpr_pkg;
	typedef enum logic [3:0] {
		CPR_IDLE  = 4'b0001,
		CPR_OUTER = 4'b0010,
		CPR_INNER = 4'b0100,
		CPR_DONE  = 4'b1000
	} cpr_state_t;
	typedef logic signed [15:0] cpr_sample_t;
endpackage : cpr_pkg

// file: cpr_top.sv
// cascaded voltage/current regulator with apb register access
`timescale 1ns/1ps
`default_nettype none
`include "cpr_map.svh"
module cpr_top
	import cpr_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic [15:0] i_ext_setpoint,
	input  wire logic [15:0] i_volt_fb,
	input  wire logic [15:0] i_curr_fb,
	input  wire logic [15:0] i_load_curr,
	input  wire logic [15:0] i_panel_setpoint,
	input  wire logic        i_panel_run,
	input  wire logic [7:0]  i_alarm_in,
	output logic      [15:0] o_drive,
	output logic             o_panel_off,
	output logic             o_running
);
	// pin inputs other than the apb bus pass two flops before use; apb inputs are used directly
	logic [15:0] ext_s1, ext_s2, vfb_s1, vfb_s2, ifb_s1, ifb_s2, ld_s1, ld_s2, pan_s1, pan_s2;
	logic        run_s1, run_s2;
	logic [7:0]  alm_s1, alm_s2;
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			{ext_s1, ext_s2, vfb_s1, vfb_s2, ifb_s1, ifb_s2} <= '0;
			{ld_s1, ld_s2, pan_s1, pan_s2, run_s1, run_s2, alm_s1, alm_s2} <= '0;
		end else begin
			ext_s1 <= i_ext_setpoint;
			ext_s2 <= ext_s1;
			vfb_s1 <= i_volt_fb;
			vfb_s2 <= vfb_s1;
			ifb_s1 <= i_curr_fb;
			ifb_s2 <= ifb_s1;
			ld_s1  <= i_load_curr;
			ld_s2  <= ld_s1;
			pan_s1 <= i_panel_setpoint;
			pan_s2 <= pan_s1;
			run_s1 <= i_panel_run;
			run_s2 <= run_s1;
			alm_s1 <= i_alarm_in;
			alm_s2 <= alm_s1;
		end
	end

	// parameter store, index 0 outer loop, 1 inner loop
	logic [15:0] kp [2];
	logic [15:0] ti [2];
	logic [15:0] td [2];
	logic [7:0]  ineg [2], ipos [2], dneg [2], dpos [2];
	logic [1:0]  sel [2];
	logic [15:0] ff_coef;
	logic [4:0]  ctrl;
	logic [15:0] host_setpoint;
	logic [31:0] time_us;
	logic [15:0] poweron;
	logic [7:0]  alarm;

	function automatic logic [15:0] sat(input logic [31:0] v, input logic [15:0] mx);
		return (v > 32'(mx)) ? mx : v[15:0];
	endfunction : sat

	wire         wr_acc = i_psel && i_penable && i_pwrite;
	wire         rd_acc = i_psel && i_penable && !i_pwrite;
	wire         in_blk = (i_paddr >= `CPR_A_OUT_KP) && (i_paddr < `CPR_A_IN_KP + 12'h020);
	wire         lp     = (i_paddr >= `CPR_A_IN_KP);
	wire  [11:0] loff   = i_paddr - (lp ? `CPR_A_IN_KP : `CPR_A_OUT_KP);
	wire         blk_ok = in_blk && (loff <= `CPR_O_SEL) && (loff[4:0] != 5'h18);

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			for (int k = 0; k < 2; k++) begin
				kp[k]   <= `CPR_RST_KP;
				ti[k]   <= `CPR_RST_TI;
				td[k]   <= `CPR_RST_TD;
				ineg[k] <= `CPR_RST_LIM;
				ipos[k] <= `CPR_RST_LIM;
				dneg[k] <= `CPR_RST_LIM;
				dpos[k] <= `CPR_RST_LIM;
				sel[k]  <= 2'b00;
			end
			ff_coef       <= 16'h0000;
			host_setpoint <= 16'h0000;
		end else if (wr_acc) begin
			if (i_paddr == `CPR_A_FF)
				ff_coef <= sat(i_pwdata, `CPR_FF_MAX);
			if (i_paddr == `CPR_A_LOCAL_SP)
				host_setpoint <= i_pwdata[15:0];
			if (blk_ok) begin
				case (loff)
					`CPR_O_KP:   kp[lp] <= sat(i_pwdata, `CPR_KP_MAX);
					`CPR_O_TI:   ti[lp] <= sat(i_pwdata, `CPR_SPAN_MAX);
					`CPR_O_TD:   td[lp] <= sat(i_pwdata, `CPR_SPAN_MAX);
					`CPR_O_ILIM: begin
						ineg[lp] <= 8'(sat({24'h0, i_pwdata[7:0]}, 16'd100));
						ipos[lp] <= 8'(sat({24'h0, i_pwdata[15:8]}, 16'd100));
					end
					`CPR_O_DLIM: begin
						dneg[lp] <= 8'(sat({24'h0, i_pwdata[7:0]}, 16'd100));
						dpos[lp] <= 8'(sat({24'h0, i_pwdata[15:8]}, 16'd100));
					end
					`CPR_O_SEL:  sel[lp] <= i_pwdata[1:0];
					default:     sel[lp] <= sel[lp];
				endcase
			end
		end
	end

	// control bits; reset and clear commands self-clear after one cycle
	always_ff @(posedge i_clk) begin
		if (!i_nrst)
			ctrl <= 5'b00000;
		else if (wr_acc && i_paddr == `CPR_A_CTRL)
			ctrl <= i_pwdata[4:0];
		else
			ctrl <= ctrl & ~(5'b00001 << `CPR_B_ALMRST) & ~(5'b00001 << `CPR_B_LOGCLR);
	end
	wire remote   = ctrl[`CPR_B_REMOTE];
	wire alm_rst  = ctrl[`CPR_B_ALMRST];
	wire log_clr  = ctrl[`CPR_B_LOGCLR];

	// time base: microsecond tick, counter restarts at power-up
	logic [7:0] us_div;
	wire        us_tick = (us_div == 8'(`CPR_US_CYC - 1));
	always_ff @(posedge i_clk) begin
		if (!i_nrst)
			us_div <= 8'd0;
		else
			us_div <= us_tick ? 8'd0 : us_div + 8'd1;
	end
	always_ff @(posedge i_clk) begin
		if (!i_nrst)
			time_us <= 32'h0000_0000;
		else if (wr_acc && i_paddr == `CPR_A_TIME)
			time_us <= i_pwdata;
		else if (us_tick)
			time_us <= time_us + 32'd1;
	end

	// power-on count is bumped once per reset release
	logic pwr_seen;
	always_ff @(posedge i_clk) begin
		if (!i_nrst)
			pwr_seen <= 1'b0;
		else
			pwr_seen <= 1'b1;
	end
	always_ff @(posedge i_clk) begin
		if (wr_acc && i_paddr == `CPR_A_POWERON)
			poweron <= i_pwdata[15:0];
		else if (i_nrst && !pwr_seen)
			poweron <= poweron + 16'd1;
	end

	// alarms latch; host reset clears them, a new event wins
	logic [7:0] new_alm;
	assign new_alm = alm_s2 & ~alarm;
	always_ff @(posedge i_clk) begin
		if (!i_nrst)
			alarm <= 8'h00;
		else
			alarm <= (alm_rst ? 8'h00 : alarm) | alm_s2;
	end
	logic [15:0] alm_code;
	always_comb begin
		alm_code = 16'h0000;
		for (int b = 7; b >= 0; b--)
			if (new_alm[b])
				alm_code = 16'(b + 1);
	end

	logic [31:0] log_data;
	logic [3:0]  log_count;
	cpr_log u_log (
		.i_clk     (i_clk),
		.i_nrst    (i_nrst),
		.i_push    (new_alm != 8'h00),
		.i_code    (alm_code),
		.i_poweron (poweron),
		.i_clear   (log_clr),
		.i_rd_idx  (i_pwdata[2:0]),
		.o_rd_data (log_data),
		.o_count   (log_count)
	);
	logic [2:0] log_idx;
	always_ff @(posedge i_clk) begin
		if (!i_nrst)
			log_idx <= 3'd0;
		else if (wr_acc && i_paddr == `CPR_A_LOGRD)
			log_idx <= i_pwdata[2:0];
	end

	// fixed sample strobe; outer then inner evaluated in sequence
	logic [12:0] samp_cnt;
	wire         samp_tick = (samp_cnt == 13'(`CPR_SAMPLE_CYC - 1));
	always_ff @(posedge i_clk) begin
		if (!i_nrst)
			samp_cnt <= 13'd0;
		else
			samp_cnt <= samp_tick ? 13'd0 : samp_cnt + 13'd1;
	end

	cpr_state_t state;
	always_ff @(posedge i_clk) begin
		if (!i_nrst)
			state <= CPR_IDLE;
		else begin
			case (state)
				CPR_IDLE:  state <= samp_tick ? CPR_OUTER : CPR_IDLE;
				CPR_OUTER: state <= CPR_INNER;
				CPR_INNER: state <= CPR_DONE;
				CPR_DONE:  state <= CPR_IDLE;
				default:   state <= CPR_IDLE;
			endcase
		end
	end

	// remote mode shuts out panel run, panel setpoint and the external setpoint; feedback and load current stay in use
	wire        run      = remote ? ctrl[`CPR_B_RUN] : run_s2;
	logic [15:0] setpoint;
	always_comb begin
		if (ctrl[`CPR_B_EXTREF] && !remote)
			setpoint = ext_s2;
		else if (remote)
			setpoint = host_setpoint;
		else
			setpoint = pan_s2;
	end

	logic signed [15:0] outer_y, inner_y, inner_ref;
	cpr_pid u_outer (
		.i_clk    (i_clk),
		.i_nrst   (i_nrst && run),
		.i_step   (state == CPR_OUTER),
		.i_ref    ($signed(setpoint)),
		.i_fb     ($signed(vfb_s2)),
		.i_kp     (kp[0]),
		.i_ti     (ti[0]),
		.i_td     (td[0]),
		.i_ineg   (ineg[0]),
		.i_ipos   (ipos[0]),
		.i_dneg   (dneg[0]),
		.i_dpos   (dpos[0]),
		.i_iscale (sel[0][0]),
		.i_dscale (sel[0][1]),
		.o_y      (outer_y)
	);

	// feed-forward adds load current share to the demand
	logic signed [31:0] demand;
	always_comb begin
		demand = 32'(outer_y) + ((32'($signed(ld_s2)) * $signed(32'(ff_coef))) >>> 4);
		if (demand > 32'sd32767)
			demand = 32'sd32767;
		else if (demand < -32'sd32768)
			demand = -32'sd32768;
	end
	always_ff @(posedge i_clk) begin
		if (!i_nrst)
			inner_ref <= 16'sd0;
		else if (state == CPR_OUTER)
			inner_ref <= demand[15:0];
	end

	cpr_pid u_inner (
		.i_clk    (i_clk),
		.i_nrst   (i_nrst && run),
		.i_step   (state == CPR_INNER),
		.i_ref    (inner_ref),
		.i_fb     ($signed(ifb_s2)),
		.i_kp     (kp[1]),
		.i_ti     (ti[1]),
		.i_td     (td[1]),
		.i_ineg   (ineg[1]),
		.i_ipos   (ipos[1]),
		.i_dneg   (dneg[1]),
		.i_dpos   (dpos[1]),
		.i_iscale (sel[1][0]),
		.i_dscale (sel[1][1]),
		.o_y      (inner_y)
	);

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_drive     <= 16'h0000;
			o_panel_off <= 1'b0;
			o_running   <= 1'b0;
		end else begin
			// drive is zeroed directly while stopped, so it drops at once, not at the next sample; the loops also sit in reset
			if (!run)
				o_drive <= 16'h0000;
			else if (state == CPR_DONE)
				o_drive <= inner_y;
			o_panel_off <= remote || !run;
			o_running   <= run;
		end
	end

	// apb slave: one wait-free access phase, unmapped reads zero with error, except unaligned loop-block offsets, which read zero without error
	logic [31:0] rd_mux;
	logic        hit;
	always_comb begin
		hit    = 1'b1;
		rd_mux = 32'h0000_0000;
		case (i_paddr)
			`CPR_A_CTRL:     rd_mux = {27'h0, ctrl};
			`CPR_A_STATUS:   rd_mux = {24'h0, 3'b000, run, state};
			`CPR_A_FF:       rd_mux = {16'h0, ff_coef};
			`CPR_A_PERIOD:   rd_mux = {16'h0, `CPR_SAMPLE_US};
			`CPR_A_TIME:     rd_mux = time_us;
			`CPR_A_POWERON:  rd_mux = {16'h0, poweron};
			`CPR_A_ALARM:    rd_mux = {24'h0, alarm};
			`CPR_A_LOGCNT:   rd_mux = {25'h0, log_idx, log_count};
			`CPR_A_LOGRD:    rd_mux = log_data;
			`CPR_A_LOCAL_SP: rd_mux = {16'h0, host_setpoint};
			default: begin
				hit = blk_ok;
				case (loff)
					`CPR_O_KP:   rd_mux = {16'h0, kp[lp]};
					`CPR_O_TI:   rd_mux = {16'h0, ti[lp]};
					`CPR_O_TD:   rd_mux = {16'h0, td[lp]};
					`CPR_O_ILIM: rd_mux = {16'h0, ipos[lp], ineg[lp]};
					`CPR_O_DLIM: rd_mux = {16'h0, dpos[lp], dneg[lp]};
					`CPR_O_SEL:  rd_mux = {30'h0, sel[lp]};
					default:     rd_mux = 32'h0000_0000;
				endcase
				if (!blk_ok)
					rd_mux = 32'h0000_0000;
			end
		endcase
	end
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_prdata  <= 32'h0000_0000;
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready  <= i_psel && !i_penable;
			o_pslverr <= i_psel && !i_penable && !hit;
			if (i_psel && !i_penable && !i_pwrite)
				o_prdata <= rd_mux;
		end
	end
endmodule : cpr_top
`default_nettype wire

// file: tb_top.sv
// self-checking bench: registers, alarms, log and loop behaviour of the regulator
`timescale 1ns/1ps
`default_nettype none
`include "cpr_map.svh"
module tb_top;
	logic        clk, nrst, psel, penable, pwrite, pready, pslverr, prun, poff, run, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] ext_sp, vfb, cfb, lcur, psp, drive;
	logic [7:0]  alm;
	logic [11:0] ta [11];
	logic [31:0] tw [11];
	logic [31:0] te [11];
	int          n_errors, n_tests;
	cpr_top uut (.i_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_ext_setpoint(ext_sp), .i_volt_fb(vfb), .i_curr_fb(cfb), .i_load_curr(lcur),
		.i_panel_setpoint(psp), .i_panel_run(prun), .i_alarm_in(alm), .o_drive(drive),
		.o_panel_off(poff), .o_running(run));
	cpr_host u_host (.i_clk(clk), .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr),
		.o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata));
	initial clk = 1'b0;
	always #4 clk = ~clk;
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		u_host.xfer(1'b1, a, d, q, e);
	endtask : wr
	task automatic rd(input logic [11:0] a);
		u_host.xfer(1'b0, a, 32'h0000_0000, q, e);
	endtask : rd
	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		rd(a);
		chk(q, exp);
	endtask : rdchk
	task automatic do_reset();
		nrst <= 1'b0;
		cyc(3);
		nrst <= 1'b1;
	endtask : do_reset
	initial begin
		cyc(60000);
		n_errors++;
		stop_test();
	end
	initial begin
		n_errors = 0;
		n_tests = 0;
		nrst = 1'b0;
		{ext_sp, vfb, cfb, lcur, psp} = 80'h0;
		prun = 1'b0;
		alm = 8'h00;
		// out-of-range writes saturate; limit bytes are negative low, positive high
		ta = '{12'h040, 12'h044, 12'h048, 12'h04c, 12'h050, 12'h054, 12'h060, 12'h064, 12'h068,
			12'h008, 12'h024};
		tw = '{32'h0000_2711, 32'h0000_7d01, 32'h0000_0000, 32'h0000_ffff, 32'h0000_3219,
			32'h0000_0003, 32'h0000_0100, 32'h0000_7d00, 32'h0000_ffff, 32'h0000_0015, 32'h0000_0800};
		te = '{32'h0000_2710, 32'h0000_7d00, 32'h0000_0000, 32'h0000_6464, 32'h0000_3219,
			32'h0000_0003, 32'h0000_0100, 32'h0000_7d00, 32'h0000_7d00, 32'h0000_0014, 32'h0000_0800};
		do_reset();
		rdchk(`CPR_A_PERIOD, 32'h0000_001d);
		rd(12'h0fc);
		chk({31'h0000_0000, e}, 32'h0000_0001);
		chk(q, 32'h0000_0000);
		wr(`CPR_A_POWERON, 32'h0000_0007);
		do_reset();
		rdchk(`CPR_A_POWERON, 32'h0000_0008);
		for (int i = 0; i < 11; i++) begin
			wr(ta[i], tw[i]);
			rdchk(ta[i], te[i]);
		end
		wr(`CPR_A_TIME, 32'h0000_0000);
		cyc(1250);
		rd(`CPR_A_TIME);
		chk({31'h0000_0000, q >= 32'd10 && q <= 32'd11}, 32'h0000_0001);
		alm <= 8'h02;
		cyc(4);
		alm <= 8'h00;
		cyc(4);
		rdchk(`CPR_A_ALARM, 32'h0000_0002);
		rd(`CPR_A_LOGCNT);
		chk(q & 32'h0000_000f, 32'h0000_0001);
		rdchk(`CPR_A_LOGRD, 32'h0008_0002);
		wr(`CPR_A_CTRL, 32'h0000_0004);
		rdchk(`CPR_A_ALARM, 32'h0000_0000);
		wr(`CPR_A_CTRL, 32'h0000_0008);
		rd(`CPR_A_LOGCNT);
		chk(q & 32'h0000_000f, 32'h0000_0000);
		prun <= 1'b1;
		ext_sp <= 16'h1000;
		wr(`CPR_A_CTRL, 32'h0000_0002);
		cyc(3 * `CPR_SAMPLE_CYC);
		chk({30'h0000_0000, run, poff}, 32'h0000_0002);
		chk({31'h0000_0000, drive !== 16'h0000 && drive[15] === 1'b0}, 32'h0000_0001);
		wr(`CPR_A_CTRL, 32'h0000_0003);
		cyc(3 * `CPR_SAMPLE_CYC);
		chk({30'h0000_0000, run, poff}, 32'h0000_0001);
		chk({16'h0000, drive}, 32'h0000_0000);
		prun <= 1'b0;
		wr(`CPR_A_CTRL, 32'h0000_0013);
		cyc(3 * `CPR_SAMPLE_CYC);
		chk({30'h0000_0000, run, poff}, 32'h0000_0003);
		chk({31'h0000_0000, drive !== 16'h0000 && drive[15] === 1'b0}, 32'h0000_0001);
		// local mode, negative panel setpoint: drive must go negative, not follow the external input
		psp  <= 16'hf000;
		prun <= 1'b1;
		wr(`CPR_A_CTRL, 32'h0000_0000);
		cyc(3 * `CPR_SAMPLE_CYC);
		chk({30'h0000_0000, run, poff}, 32'h0000_0002);
		chk({31'h0000_0000, drive[15] === 1'b1}, 32'h0000_0001);
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
